// file: pkg/dts_pkg.sv
/*
 * Shared constants, types and decoding for the DMA transfer cycle sequencer.
 * Assumes one bus clock domain; the sequencer clock is the bus clock.
 */
package dts_pkg;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int CNT_W = 4;
    localparam int ACC_W = 2;
    localparam int BUF_DEPTH = 2;

    // Transfer unit select values
    localparam logic UNIT_16 = 1'b0;
    localparam logic UNIT_8 = 1'b1;

    // Bus clock periods per access
    localparam logic [1:0] COEF_NOWAIT = 2'h1;
    localparam logic [1:0] COEF_WAIT = 2'h2;
    localparam logic [1:0] COEF_SFR = 2'h2;
    localparam logic [1:0] COEF_MUX = 2'h3;

    localparam logic [ACC_W-1:0] ACC_ONE = 2'h1;
    localparam logic [ACC_W-1:0] ACC_TWO = 2'h2;

    typedef enum logic [2:0] {
        AREA_INT_NOWAIT = 3'h0,
        AREA_INT_WAIT = 3'h1,
        AREA_SFR = 3'h2,
        AREA_EXT_SEP_NOWAIT = 3'h3,
        AREA_EXT_SEP_WAIT = 3'h4,
        AREA_EXT_MUX = 3'h5
    } dts_area_t;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_EXPAND = 2'h1,
        MODE_MPROC = 2'h2
    } dts_mode_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_CPU_PRE = 6'h02,
        ST_READ = 6'h04,
        ST_CPU_MID = 6'h08,
        ST_WRITE = 6'h10,
        ST_CPU_POST = 6'h20
    } dts_state_t;

    // Bus clock periods of one access to an area
    function automatic logic [1:0] dts_coef(input dts_area_t area);
        case (area)
            AREA_INT_NOWAIT: dts_coef = COEF_NOWAIT;
            AREA_INT_WAIT: dts_coef = COEF_WAIT;
            AREA_SFR: dts_coef = COEF_SFR;
            AREA_EXT_SEP_NOWAIT: dts_coef = COEF_NOWAIT;
            AREA_EXT_SEP_WAIT: dts_coef = COEF_WAIT;
            AREA_EXT_MUX: dts_coef = COEF_MUX;
            default: dts_coef = COEF_MUX;
        endcase
    endfunction : dts_coef

    // Accesses for one side of a unit
    function automatic logic [ACC_W-1:0] dts_accesses(input logic unit8, input logic odd, input logic bus8);
        if (unit8) begin
            dts_accesses = ACC_ONE;
        end else if (odd || bus8) begin
            dts_accesses = ACC_TWO;
        end else begin
            dts_accesses = ACC_ONE;
        end
    endfunction : dts_accesses

endpackage : dts_pkg

// file: pkg/dts_buf_if.sv
/*
 * Carrier between the sequencer and its two-entry word buffer.
 * Assumes both ends on the same clock.
 */
`timescale 1ns/1ns
interface dts_buf_if;
    import dts_pkg::*;

    logic push_valid;
    logic push_ready;
    logic [DATA_W-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [DATA_W-1:0] pop_data;

    modport buf_side (
        input push_valid, push_data, pop_ready,
        output push_ready, pop_valid, pop_data
    );
    modport user_side (
        output push_valid, push_data, pop_ready,
        input push_ready, pop_valid, pop_data
    );
endinterface : dts_buf_if

// file: src/dts_buf.sv
/*
 * Two-entry word buffer with valid/ready on both sides.
 * Assumes the user never pushes while push_ready is low.
 */
`timescale 1ns/1ns
module dts_buf
    import dts_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Buffer ports
    dts_buf_if.buf_side bif
);

    typedef struct packed {
        logic [BUF_DEPTH-1:0][DATA_W-1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } dts_buf_state_t;

    dts_buf_state_t s_q;
    dts_buf_state_t s_d;
    logic do_push;
    logic do_pop;

    assign bif.push_ready = (s_q.count != 2'(BUF_DEPTH));
    assign bif.pop_valid = (s_q.count != 2'h0);
    assign bif.pop_data = s_q.mem[s_q.rd_ptr];
    assign do_push = bif.push_valid && bif.push_ready;
    assign do_pop = bif.pop_valid && bif.pop_ready;

    always_comb begin
        s_d = s_q;
        if (do_push) begin
            s_d.mem[s_q.wr_ptr] = bif.push_data;
            s_d.wr_ptr = ~s_q.wr_ptr;
        end
        if (do_pop) begin
            s_d.rd_ptr = ~s_q.rd_ptr;
        end
        case ({do_push, do_pop})
            2'b10: s_d.count = s_q.count + 2'h1;
            2'b01: s_d.count = s_q.count - 2'h1;
            default: s_d.count = s_q.count;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : dts_buf

// file: src/dts_sequencer.sv
/*
 * DMA transfer cycle sequencer: runs source read and destination write
 * bus cycles for one transfer unit, releasing the bus to the CPU around them.
 * Assumes the bus clock is clk_sys_i and the width select pin is asynchronous.
 */
// Notes on behaviour
// - Each unit is reads, then writes.
// - Odd 16-bit start adds one access each.
// - Narrow bus splits 16-bit unit into bytes.
// - Internal areas use the pin-selected width.
// - SFR or waited area adds one period.
// - Byte units take one read, one write.
// - Total is reads*j plus writes*k.
// - Coefficients 1,2,2,1,2,3 by area.
// - Any source/destination parity combination works.
// - Width pin ignored in single-chip mode.
// - Write side judged on its own conditions.
// - Select 0 means 16-bit, 1 means 8-bit.
`timescale 1ns/1ns
module dts_sequencer
    import dts_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Transfer request
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [ADDR_W-1:0] req_src_addr_i,
    input wire logic [ADDR_W-1:0] req_dst_addr_i,
    input wire logic transfer_unit_select_i,
    input wire dts_area_t req_src_area_i,
    input wire dts_area_t req_dst_area_i,
    // Configuration
    input wire logic byte_bus_pin_i,
    input wire dts_mode_t proc_mode_i,
    // Bus master
    input wire logic bus_wait_i,
    output logic bus_own_o,
    output logic cpu_slot_o,
    output logic bus_rd_o,
    output logic bus_wr_o,
    output logic bus_byte_o,
    output logic [ADDR_W-1:0] bus_addr_o,
    output logic [DATA_W-1:0] bus_wdata_o,
    input wire logic [DATA_W-1:0] bus_rdata_i,
    // Status
    output logic [CNT_W-1:0] unit_cycles_o,
    output logic unit_done_o
);

    typedef struct packed {
        dts_state_t st;
        // Width pin synchroniser
        logic pin_meta;
        logic pin_sync;

        // Unit setup and captured request
        logic unit8;
        logic bus8;
        logic [ADDR_W-1:0] src;
        logic [ADDR_W-1:0] dst;
        dts_area_t src_area;
        dts_area_t dst_area;

        // Current access
        logic [ACC_W-1:0] n_acc;
        logic [ACC_W-1:0] idx;
        logic [1:0] tick;
        logic [1:0] coef;
        logic byte_acc;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] word;
        logic [DATA_W-1:0] wdata;

        // Unit result
        logic [CNT_W-1:0] cycles;
        logic done;
    } dts_seq_state_t;

    localparam dts_seq_state_t SEQ_RESET = '{
        st: ST_IDLE,
        pin_meta: 1'b0,
        pin_sync: 1'b0,
        unit8: 1'b0,
        bus8: 1'b0,
        src: '0,
        dst: '0,
        src_area: AREA_INT_NOWAIT,
        dst_area: AREA_INT_NOWAIT,
        n_acc: '0,
        idx: '0,
        tick: '0,
        coef: '0,
        byte_acc: 1'b0,
        addr: '0,
        word: '0,
        wdata: '0,
        cycles: '0,
        done: 1'b0
    };

    dts_seq_state_t s_q;
    dts_seq_state_t s_d;
    dts_buf_if bif ();

    logic [ACC_W-1:0] rd_n;
    logic [ACC_W-1:0] wr_n;
    logic src_odd;
    logic dst_odd;
    logic [CNT_W-1:0] rd_cost;
    logic [CNT_W-1:0] wr_cost;
    logic [CNT_W-1:0] total;
    logic last_tick;
    logic last_acc;
    logic [DATA_W-1:0] next_word;
    logic [DATA_W-1:0] first_wdata;
    logic [DATA_W-1:0] hi_wdata;
    logic take;
    logic in_read;
    logic in_write;
    logic in_slot;

    ////////////////////////////////////////////////////////////////////////
    // Shared decoding

    // A byte-wide access: byte unit, narrow bus or odd start
    function automatic logic byte_wide(input logic unit8, input logic bus8, input logic odd);
        byte_wide = unit8 || bus8 || odd;
    endfunction : byte_wide

    ////////////////////////////////////////////////////////////////////////
    // Word buffer between read and write sides

    dts_buf u_buf (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .bif(bif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Access counts and per-unit cycle total

    // Each side counted from its own parity and area
    assign src_odd = req_src_addr_i[0];
    assign dst_odd = req_dst_addr_i[0];
    assign rd_n = dts_accesses(transfer_unit_select_i, src_odd, s_q.bus8);
    assign wr_n = dts_accesses(transfer_unit_select_i, dst_odd, s_q.bus8);
    // Widened before the product so two triple-length accesses keep the top bit
    assign rd_cost = CNT_W'(rd_n) * CNT_W'(dts_coef(req_src_area_i));
    assign wr_cost = CNT_W'(wr_n) * CNT_W'(dts_coef(req_dst_area_i));
    assign total = rd_cost + wr_cost;

    assign last_tick = (s_q.tick == s_q.coef - 2'h1) && !bus_wait_i;
    assign last_acc = (s_q.idx == s_q.n_acc - ACC_W'(1));

    // Assemble read data, low byte first
    always_comb begin
        next_word = s_q.word;
        if (!s_q.byte_acc) begin
            next_word = bus_rdata_i;
        end else if (s_q.idx == '0) begin
            next_word = {8'h00, bus_rdata_i[7:0]};
        end else begin
            next_word = {bus_rdata_i[7:0], s_q.word[7:0]};
        end
    end

    // Write data of the first access; a byte rides on bits 7:0
    always_comb begin
        first_wdata = bif.pop_data;
        if (byte_wide(s_q.unit8, s_q.bus8, s_q.dst[0])) begin
            first_wdata = {8'h00, bif.pop_data[7:0]};
        end
    end

    // High byte of a split unit goes second
    assign hi_wdata = {8'h00, s_q.word[15:8]};

    ////////////////////////////////////////////////////////////////////////
    // State decodes and buffer handshakes

    assign in_read = (s_q.st == ST_READ);
    assign in_write = (s_q.st == ST_WRITE);
    assign in_slot = (s_q.st == ST_CPU_PRE) || (s_q.st == ST_CPU_MID) || (s_q.st == ST_CPU_POST);
    assign take = req_valid_i && (s_q.st == ST_IDLE);

    // Last read access hands the word over
    assign bif.push_valid = in_read && last_tick && last_acc;
    assign bif.push_data = next_word;
    assign bif.pop_ready = (s_q.st == ST_CPU_MID);

    ////////////////////////////////////////////////////////////////////////
    // Sequencing

    always_comb begin
        s_d = s_q;
        // Width pin through two flops, then gated by mode
        s_d.pin_meta = byte_bus_pin_i;
        s_d.pin_sync = s_q.pin_meta;
        s_d.bus8 = s_q.pin_sync && (proc_mode_i != MODE_SINGLE);
        s_d.done = 1'b0;
        case (s_q.st)
            ST_IDLE: begin
                if (take) begin
                    s_d.unit8 = transfer_unit_select_i;
                    s_d.src = req_src_addr_i;
                    s_d.dst = req_dst_addr_i;
                    s_d.src_area = req_src_area_i;
                    s_d.dst_area = req_dst_area_i;
                    s_d.n_acc = rd_n;
                    s_d.cycles = total;
                    s_d.st = ST_CPU_PRE;
                end
            end
            ST_CPU_PRE: begin
                // Bus left to the CPU for one period
                s_d.st = ST_READ;
                s_d.idx = '0;
                s_d.tick = '0;
                s_d.addr = s_q.src;
                s_d.coef = dts_coef(s_q.src_area);
                s_d.byte_acc = byte_wide(s_q.unit8, s_q.bus8, s_q.src[0]);
            end
            ST_READ: begin
                if (!last_tick) begin
                    if (!bus_wait_i) begin
                        s_d.tick = s_q.tick + 2'h1;
                    end
                end else if (!last_acc) begin
                    s_d.word = next_word;
                    s_d.idx = s_q.idx + ACC_W'(1);
                    s_d.addr = s_q.addr + ADDR_W'(1);
                    s_d.tick = '0;
                end else if (bif.push_ready) begin
                    // Buffer room taken before the read side lets go
                    s_d.word = next_word;
                    s_d.st = ST_CPU_MID;
                end
            end
            ST_CPU_MID: begin
                if (bif.pop_valid) begin
                    s_d.st = ST_WRITE;
                    s_d.word = bif.pop_data;
                    s_d.idx = '0;
                    s_d.tick = '0;
                    s_d.addr = s_q.dst;
                    s_d.coef = dts_coef(s_q.dst_area);
                    s_d.n_acc = dts_accesses(s_q.unit8, s_q.dst[0], s_q.bus8);
                    s_d.byte_acc = byte_wide(s_q.unit8, s_q.bus8, s_q.dst[0]);
                    s_d.wdata = first_wdata;
                end
            end
            ST_WRITE: begin
                if (!last_tick) begin
                    if (!bus_wait_i) begin
                        s_d.tick = s_q.tick + 2'h1;
                    end
                end else if (!last_acc) begin
                    // Second byte of a split unit
                    s_d.idx = s_q.idx + ACC_W'(1);
                    s_d.addr = s_q.addr + ADDR_W'(1);
                    s_d.wdata = hi_wdata;
                    s_d.tick = '0;
                end else begin
                    s_d.st = ST_CPU_POST;
                end
            end
            ST_CPU_POST: begin
                s_d.done = 1'b1;
                s_d.st = ST_IDLE;
            end
            default: begin
                s_d = SEQ_RESET;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            s_q <= SEQ_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Handshake and bus phase
    assign req_ready_o = (s_q.st == ST_IDLE);
    assign bus_rd_o = in_read;
    assign bus_wr_o = in_write;
    assign bus_own_o = in_read || in_write;
    assign cpu_slot_o = in_slot;

    // Access registers
    assign bus_byte_o = s_q.byte_acc;
    assign bus_addr_o = s_q.addr;
    assign bus_wdata_o = s_q.wdata;

    // Unit result
    assign unit_cycles_o = s_q.cycles;
    assign unit_done_o = s_q.done;

endmodule : dts_sequencer

// file: verif/dts_sequencer_asserts.sv
/*
 * Concurrent checks on the sequencer's ports, bound to dts_sequencer.
 * Assumes one clock domain and an asynchronous active-high reset.
 */
`timescale 1ns/1ns
module dts_sequencer_asserts
    import dts_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // Request
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic transfer_unit_select_i,
    input wire dts_area_t req_src_area_i,
    input wire dts_area_t req_dst_area_i,
    // Bus and status
    input wire logic bus_own_o,
    input wire logic cpu_slot_o,
    input wire logic bus_rd_o,
    input wire logic bus_wr_o,
    input wire logic bus_byte_o,
    input wire logic [DATA_W-1:0] bus_wdata_o,
    input wire logic [CNT_W-1:0] unit_cycles_o,
    input wire logic unit_done_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    logic take;
    assign take = req_valid_i && req_ready_o;
    function automatic logic [CNT_W-1:0] cf(input dts_area_t a);
        cf = (a == AREA_INT_NOWAIT || a == AREA_EXT_SEP_NOWAIT) ? 4'h1 : (a == AREA_EXT_MUX) ? 4'h3 : 4'h2;
    endfunction : cf
    ////////////////////////////////////////////////////////////////////////////
    a_rd_wr_apart: assert property (!(bus_rd_o && bus_wr_o)) else $error("read and write overlap");
    a_own_no_slot: assert property (bus_own_o == (bus_rd_o || bus_wr_o) && !(bus_own_o && cpu_slot_o))
        else $error("bus owner mixed with cpu slot");
    a_take_cpu_slot: assert property (take |=> cpu_slot_o && !req_ready_o) else $error("no cpu slot after take");
    a_read_after_slot: assert property ($rose(bus_rd_o) |-> $past(cpu_slot_o)) else $error("read not after slot");
    a_write_after_slot: assert property ($rose(bus_wr_o) |-> $past(cpu_slot_o)) else $error("write not after slot");
    a_slot_after_write: assert property ($fell(bus_wr_o) |-> cpu_slot_o) else $error("no slot after write");
    a_done_one_cycle: assert property (unit_done_o |=> !unit_done_o) else $error("done longer than a cycle");
    a_byte_unit_cycles: assert property (take && transfer_unit_select_i == UNIT_8 |=>
        unit_cycles_o == cf($past(req_src_area_i)) + cf($past(req_dst_area_i))) else $error("byte unit count");
    a_byte_upper_zero: assert property (bus_wr_o && bus_byte_o |-> bus_wdata_o[15:8] == 8'h00)
        else $error("byte write upper lane");
    a_cycles_held: assert property (!take |=> $stable(unit_cycles_o)) else $error("cycle count moved");
endmodule : dts_sequencer_asserts

bind dts_sequencer dts_sequencer_asserts u_asserts (.clk_sys_i, .rst_i, .req_valid_i, .req_ready_o,
    .transfer_unit_select_i, .req_src_area_i, .req_dst_area_i, .bus_own_o, .cpu_slot_o, .bus_rd_o, .bus_wr_o,
    .bus_byte_o, .bus_wdata_o, .unit_cycles_o, .unit_done_o);

// file: verif/dts_mem_model.sv
/*
 * Memory seen by the sequencer's bus: address-derived read data and waits.
 * Assumes the bench holds slow_i steady during a unit.
 */
`timescale 1ns/1ns
module dts_mem_model
    import dts_pkg::*;
(
    // Clock and pace
    input wire logic clk_sys_i,
    input wire logic slow_i,
    // Memory bus
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [ADDR_W-1:0] addr_i,
    output logic wait_o,
    output logic [DATA_W-1:0] rdata_o
);
    logic [DATA_W-1:0] last_q = '0;
    function automatic logic [7:0] bt(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : bt
    // Released bus shows the inverse of the last word
    assign rdata_o = rd_i ? {bt(addr_i + 1'b1), bt(addr_i)} : ~last_q;
    always @(posedge clk_sys_i) begin
        if (rd_i) begin
            last_q <= rdata_o;
        end
        wait_o <= slow_i & (rd_i | wr_i) & ~wait_o;
    end
endmodule : dts_mem_model

// file: verif/dts_sequencer_tb_top.sv
/*
 * Self-checking bench: random units compared with a counting model.
 * Assumes dts_mem_model as the bus partner.
 */
`timescale 1ns/1ns
module dts_sequencer_tb_top;
    import dts_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic transfer_unit_select_i = 1'b0;
    logic byte_bus_pin_i = 1'b0;
    logic slow = 1'b0;
    logic [ADDR_W-1:0] req_src_addr_i = '0;
    logic [ADDR_W-1:0] req_dst_addr_i = '0;
    dts_area_t req_src_area_i = AREA_INT_NOWAIT;
    dts_area_t req_dst_area_i = AREA_INT_NOWAIT;
    dts_mode_t proc_mode_i = MODE_SINGLE;
    logic req_ready_o, bus_wait_i, bus_own_o, cpu_slot_o, bus_rd_o, bus_wr_o, bus_byte_o, unit_done_o;
    logic [ADDR_W-1:0] bus_addr_o, la;
    logic [DATA_W-1:0] bus_wdata_o, bus_rdata_i;
    logic [CNT_W-1:0] unit_cycles_o;
    logic lr, lw;
    logic [36:0] wq[$];
    int num_errors = 0;
    int tests_run = 0;
    int rd_n = 0;
    int seed = 32'h8999;
    always #25 clk_sys_i = ~clk_sys_i;
    dts_sequencer DUT (.clk_sys_i, .rst_i, .req_valid_i, .req_ready_o, .req_src_addr_i, .req_dst_addr_i,
        .transfer_unit_select_i, .req_src_area_i, .req_dst_area_i, .byte_bus_pin_i, .proc_mode_i,
        .bus_wait_i, .bus_own_o, .cpu_slot_o, .bus_rd_o, .bus_wr_o, .bus_byte_o, .bus_addr_o,
        .bus_wdata_o, .bus_rdata_i, .unit_cycles_o, .unit_done_o);
    dts_mem_model u_mem (.clk_sys_i, .slow_i(slow), .rd_i(bus_rd_o), .wr_i(bus_wr_o), .addr_i(bus_addr_o),
        .wait_o(bus_wait_i), .rdata_o(bus_rdata_i));
    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] bt(input logic [ADDR_W-1:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction : bt
    function automatic int cf(input dts_area_t a);
        return (a == AREA_INT_NOWAIT || a == AREA_EXT_SEP_NOWAIT) ? 1 : (a == AREA_EXT_MUX) ? 3 : 2;
    endfunction : cf
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %0h, seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic give_verdict;
        $display("checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////
    // One record per distinct access
    always @(posedge clk_sys_i) begin
        if (bus_rd_o && !(lr && la === bus_addr_o)) rd_n++;
        if (bus_wr_o && !(lw && la === bus_addr_o)) wq.push_back({bus_byte_o, bus_addr_o, bus_wdata_o});
        lr = bus_rd_o;
        lw = bus_wr_o;
        la = bus_addr_o;
    end
    task automatic xfer(input int n);
        logic [ADDR_W-1:0] s, d;
        logic [36:0] e;
        int r, w, t, cyc, k;
        s = $random(seed);
        d = $random(seed);
        @(posedge clk_sys_i);
        #1;
        byte_bus_pin_i = $random(seed);
        transfer_unit_select_i = $random(seed);
        proc_mode_i = dts_mode_t'(n % 3);
        slow = n[2];
        req_src_area_i = dts_area_t'(($random(seed) & 32'hFF) % 6);
        req_dst_area_i = dts_area_t'(($random(seed) & 32'hFF) % 6);
        // Width pin needs its synchroniser settled
        repeat (4) @(posedge clk_sys_i);
        #1;
        req_src_addr_i = s;
        req_dst_addr_i = d;
        req_valid_i = 1'b1;
        @(posedge clk_sys_i);
        #1;
        req_valid_i = 1'b0;
        rd_n = 0;
        wq.delete();
        r = transfer_unit_select_i ? 1 : (s[0] || (byte_bus_pin_i && proc_mode_i != MODE_SINGLE)) ? 2 : 1;
        w = transfer_unit_select_i ? 1 : (d[0] || (byte_bus_pin_i && proc_mode_i != MODE_SINGLE)) ? 2 : 1;
        t = r * cf(req_src_area_i) + w * cf(req_dst_area_i);
        cyc = 0;
        while (unit_done_o !== 1'b1) begin
            @(posedge clk_sys_i);
            #1;
            cyc++;
            if (cyc > 200) begin
                num_errors++;
                give_verdict();
            end
        end
        chk("unit_cycles_o", unit_cycles_o, t);
        if (!slow) chk("unit latency", cyc, t + 3);
        chk("read accesses", rd_n, r);
        chk("write accesses", wq.size(), w);
        chk("req_ready_o", req_ready_o, 1);
        foreach (wq[i]) begin
            e = wq[i];
            k = e[35:16] - d;
            if (i == 0) chk("first write address", e[35:16], d);
            chk("write low byte", e[7:0], bt(s + k));
            if (!e[36]) chk("write high byte", e[15:8], bt(s + k + 1));
        end
    endtask : xfer
    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1;
        rst_i = 1'b0;
        for (int n = 0; n < 96; n++) xfer(n);
        give_verdict();
    end
endmodule : dts_sequencer_tb_top
